// ===== rtl/srs_pkg.sv
// Constants and carriers for the serial transceiver reset sequencer.
// Assumes a 50 MHz free-running clock and single-bit ANDed status inputs.
package srs_pkg;

    // Free-running clock and reset pulse width
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned PLL_RST_NS    = 1000;
    localparam int unsigned PLL_RST_CYC   =
        (PLL_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0]  PLL_RST_CNT   = 8'(PLL_RST_CYC);
    localparam logic [7:0]  CNT_ZERO      = 8'h00;

    // Sequencer states per direction
    typedef enum logic [2:0] {
        SRS_PLL_RST  = 3'b000,
        SRS_PLL_WAIT = 3'b001,
        SRS_CH_WAIT  = 3'b010,
        SRS_DONE     = 3'b011,
        SRS_IDLE     = 3'b100
    } srs_state_e;

    // Status of one direction, already in the free-running domain
    typedef struct packed {
        logic pll_lock;
        logic cdr_lock;
        logic reset_done;
        logic usr_active;
    } srs_stat_s;

    // Reset controls of one direction toward the channels
    typedef struct packed {
        logic pll_reset;
        logic prog_div_reset;
        logic chan_reset;
        logic user_ready;
    } srs_ctrl_s;

endpackage

// ===== rtl/srs_top.sv
// Reset sequencer for a group of transceiver channels and their PLLs.
// Status and request inputs arrive asynchronously; outputs are used
// asynchronously by the channels; done flags cross into user clocks.
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for one level
module srs_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic d,
    output logic      q
);
    logic meta;

    // First flop feeds only the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// One direction of the sequence: PLL reset, lock, channel, user-ready
module srs_dir
    import srs_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_b,
    input  wire logic      start,
    input  wire logic      data_only,
    input  wire logic      skip_pll,
    input  wire logic      pwr_good,
    input  wire logic      need_cdr,
    input  wire srs_stat_s stat,
    output srs_ctrl_s      ctrl,
    output logic           done
);
    srs_state_e state;
    srs_state_e next_state;
    logic [7:0] cnt;
    logic       cnt_zero;
    logic       lock_ok;
    logic       chan_ok;

    // Completion conditions
    assign cnt_zero = (cnt == CNT_ZERO);
    assign lock_ok  = stat.pll_lock & pwr_good;
    assign chan_ok  = stat.reset_done & stat.usr_active &
                      (stat.cdr_lock | ~need_cdr);

    // Next-state decode
    always_comb begin
        next_state = state;
        case (state)
            SRS_PLL_RST:  if (cnt_zero) next_state = SRS_PLL_WAIT;
            SRS_PLL_WAIT: if (lock_ok) next_state = SRS_CH_WAIT;
            SRS_CH_WAIT:  if (chan_ok) next_state = SRS_DONE;
            SRS_DONE:     next_state = SRS_DONE;
            SRS_IDLE:     next_state = SRS_IDLE;
            default:      next_state = SRS_PLL_RST;
        endcase
        if (start) begin
            next_state = (data_only | skip_pll) ? SRS_PLL_WAIT
                                                : SRS_PLL_RST;
        end
    end

    // State and PLL reset counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= SRS_PLL_RST;
            cnt   <= PLL_RST_CNT;
        end else begin
            state <= next_state;
            // A new PLL-resetting request in the PLL phase restarts the full width
            cnt   <= (next_state == SRS_PLL_RST &&
                      (state != SRS_PLL_RST || start))
                     ? PLL_RST_CNT
                     : (cnt_zero ? cnt : cnt - 8'h01);
        end
    end

    // Registered controls toward the channels
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= '{1'b1, 1'b1, 1'b1, 1'b0};
            done <= 1'b0;
        end else begin
            ctrl.pll_reset      <= (next_state == SRS_PLL_RST);
            ctrl.prog_div_reset <= (next_state == SRS_PLL_RST) ||
                                   (next_state == SRS_PLL_WAIT);
            ctrl.chan_reset     <= (next_state == SRS_PLL_RST) ||
                                   (next_state == SRS_PLL_WAIT);
            ctrl.user_ready     <= (next_state == SRS_CH_WAIT ||
                                    next_state == SRS_DONE) &&
                                   stat.usr_active;
            done                <= (next_state == SRS_DONE);
        end
    end
endmodule

// Top of the sequencer
module srs_top
    import srs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic reset_all,
    input  wire logic reset_tx_pll_and_datapath,
    input  wire logic reset_tx_datapath,
    input  wire logic reset_rx_pll_and_datapath,
    input  wire logic reset_rx_datapath,
    input  wire logic tx_usr_clk_active,
    input  wire logic rx_usr_clk_active,
    input  wire logic power_good,
    input  wire logic tx_pll_lock,
    input  wire logic tx_reset_done,
    input  wire logic rx_pll_lock,
    input  wire logic rx_cdr_lock,
    input  wire logic rx_reset_done,
    input  wire logic tx_enabled_tie,
    input  wire logic rx_enabled_tie,
    input  wire logic shared_pll_tie,
    input  wire logic tx_master_user_clock,
    input  wire logic rx_master_user_clock,
    output logic      tx_pll_reset,
    output logic      tx_prog_div_reset,
    output logic      tx_chan_reset,
    output logic      tx_user_ready,
    output logic      rx_pll_reset,
    output logic      rx_prog_div_reset,
    output logic      rx_chan_reset,
    output logic      rx_user_ready,
    output logic      tx_done,
    output logic      rx_done
);
    localparam int NIN = 13;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sync_in;
    logic [NIN-1:0] req_q;
    logic           s_all, s_txpd, s_txd, s_rxpd, s_rxd;
    logic           all_rise, txpd_rise, txd_rise, rxpd_rise, rxd_rise;
    logic           tx_start, rx_start, tx_data_only, rx_data_only;
    logic           rx_skip_pll;
    srs_stat_s      tx_stat, rx_stat;
    srs_ctrl_s      tx_ctrl, rx_ctrl;
    logic           tx_done_fr, rx_done_fr;
    logic           tx_done_sync, rx_done_sync;

    assign raw_in = {reset_all, reset_tx_pll_and_datapath, reset_tx_datapath,
                     reset_rx_pll_and_datapath, reset_rx_datapath,
                     tx_usr_clk_active, rx_usr_clk_active, power_good,
                     tx_pll_lock, tx_reset_done, rx_pll_lock,
                     rx_cdr_lock, rx_reset_done};

    // Every asynchronous input passes a two-flop synchroniser
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            srs_sync u_sync (
                .clk   (clk),
                .rst_b (rst_b),
                .d     (raw_in[gi]),
                .q     (sync_in[gi])
            );
        end
    endgenerate

    // Request edge detection on synchronised levels
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_q <= '0;
        end else begin
            req_q <= sync_in;
        end
    end

    assign {s_all, s_txpd, s_txd, s_rxpd, s_rxd} = sync_in[12:8];
    assign all_rise  = s_all  & ~req_q[12];
    assign txpd_rise = s_txpd & ~req_q[11];
    assign txd_rise  = s_txd  & ~req_q[10];
    assign rxpd_rise = s_rxpd & ~req_q[9];
    assign rxd_rise  = s_rxd  & ~req_q[8];

    // Start decode: full reset honours the enable tie-offs
    assign tx_start     = (all_rise & tx_enabled_tie) | txpd_rise |
                          txd_rise;
    assign rx_start     = (all_rise & rx_enabled_tie) | rxpd_rise |
                          rxd_rise;
    assign tx_data_only = txd_rise & ~all_rise & ~txpd_rise;
    assign rx_data_only = rxd_rise & ~all_rise & ~rxpd_rise;
    // Full reset: shared PLL reset only once, by the transmit side if it is enabled
    assign rx_skip_pll  = all_rise & shared_pll_tie &
                          tx_enabled_tie;

    assign tx_stat = '{sync_in[4], 1'b1, sync_in[3], sync_in[7]};
    assign rx_stat = '{sync_in[2], sync_in[1], sync_in[0], sync_in[6]};

    // Transmit direction
    srs_dir u_tx (
        .clk       (clk),
        .rst_b     (rst_b),
        .start     (tx_start),
        .data_only (tx_data_only),
        .skip_pll  (1'b0),
        .pwr_good  (sync_in[5]),
        .need_cdr  (1'b0),
        .stat      (tx_stat),
        .ctrl      (tx_ctrl),
        .done      (tx_done_fr)
    );

    // Receive direction
    srs_dir u_rx (
        .clk       (clk),
        .rst_b     (rst_b),
        .start     (rx_start),
        .data_only (rx_data_only),
        .skip_pll  (rx_skip_pll),
        .pwr_good  (sync_in[5]),
        .need_cdr  (1'b1),
        .stat      (rx_stat),
        .ctrl      (rx_ctrl),
        .done      (rx_done_fr)
    );

    // Channel controls, registered in the free-running domain
    assign tx_pll_reset      = tx_ctrl.pll_reset;
    assign tx_prog_div_reset = tx_ctrl.prog_div_reset;
    assign tx_chan_reset     = tx_ctrl.chan_reset;
    assign tx_user_ready     = tx_ctrl.user_ready;
    assign rx_pll_reset      = rx_ctrl.pll_reset;
    assign rx_prog_div_reset = rx_ctrl.prog_div_reset;
    assign rx_chan_reset     = rx_ctrl.chan_reset;
    assign rx_user_ready     = rx_ctrl.user_ready;

    // Done flags cross into the master user clock domains
    srs_sync u_txd (
        .clk   (tx_master_user_clock),
        .rst_b (rst_b),
        .d     (tx_done_fr),
        .q     (tx_done_sync)
    );
    srs_sync u_rxd (
        .clk   (rx_master_user_clock),
        .rst_b (rst_b),
        .d     (rx_done_fr),
        .q     (rx_done_sync)
    );

    always_ff @(posedge tx_master_user_clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_done <= 1'b0;
        end else begin
            tx_done <= tx_done_sync;
        end
    end

    always_ff @(posedge rx_master_user_clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_done <= 1'b0;
        end else begin
            rx_done <= rx_done_sync;
        end
    end
endmodule

`default_nettype wire

// ===== tb/srs_properties.sv
// Concurrent checks on the reset sequencer's ports.
// Bound into srs_top; the done flags are sampled on their user clocks.
`timescale 1ns/1ps
`default_nettype none
module srs_properties
    import srs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tx_usr_clk_active,
    input wire logic rx_usr_clk_active,
    input wire logic power_good,
    input wire logic tx_pll_lock,
    input wire logic tx_pll_reset,
    input wire logic tx_chan_reset,
    input wire logic tx_user_ready,
    input wire logic rx_pll_reset,
    input wire logic rx_chan_reset,
    input wire logic rx_user_ready,
    input wire logic tx_done,
    input wire logic rx_done,
    input wire logic tx_master_user_clock,
    input wire logic rx_master_user_clock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Lock and power seen through the synchroniser before release
    sequence s_tx_locked;
        $past(tx_pll_lock, 3) && $past(power_good, 3) && !tx_pll_reset;
    endsequence
    // Ordering and width of the reset phases
    a_tx_pll_len: assert property ($fell(tx_pll_reset) |->
        $past(tx_pll_reset, PLL_RST_CYC)) else $error("tx pll reset short");
    a_tx_chan_lock: assert property ($fell(tx_chan_reset) |->
        s_tx_locked) else $error("tx channel released before lock");
    a_tx_ready_order: assert property (tx_user_ready |->
        !tx_pll_reset && !tx_chan_reset) else $error("tx ready too early");
    a_rx_ready_order: assert property (rx_user_ready |->
        !rx_pll_reset && !rx_chan_reset) else $error("rx ready too early");
    // User-ready only after the active level has passed the synchroniser
    a_tx_ready_sync: assert property ($rose(tx_user_ready) |->
        $past(tx_usr_clk_active, 3)) else $error("tx ready without active");
    a_rx_ready_sync: assert property ($rose(rx_user_ready) |->
        $past(rx_usr_clk_active, 3)) else $error("rx ready without active");
    // Done flags in user clocks follow a finished sequence
    a_tx_done_ready: assert property (@(posedge tx_master_user_clock)
        $rose(tx_done) |-> tx_user_ready) else $error("tx done early");
    a_rx_done_ready: assert property (@(posedge rx_master_user_clock)
        $rose(rx_done) |-> rx_user_ready) else $error("rx done early");
endmodule
bind srs_top srs_properties srs_properties_i (
    .clk, .rst_b, .tx_usr_clk_active, .rx_usr_clk_active, .power_good,
    .tx_pll_lock, .tx_pll_reset, .tx_chan_reset, .tx_user_ready,
    .rx_pll_reset, .rx_chan_reset, .rx_user_ready, .tx_done, .rx_done,
    .tx_master_user_clock, .rx_master_user_clock
);
`default_nettype wire

// ===== tb/srs_partner.sv
// Model of the channels, their PLLs and the user clocking side.
// Counters stand in for lock and reset-done times after each release.
`timescale 1ns/1ps
`default_nettype none
module srs_partner
    import srs_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      slow,
    input  wire logic      shared,
    input  wire srs_ctrl_s txc,
    input  wire srs_ctrl_s rxc,
    output logic           tx_pll_lock,
    output logic           rx_pll_lock,
    output logic           rx_cdr_lock,
    output logic           tx_reset_done,
    output logic           rx_reset_done,
    output var logic       tx_uclk,
    output var logic       rx_uclk
);
    logic [7:0] cnt [4];
    logic [7:0] dly;
    logic [3:0] clr;
    // Each counter restarts while its resource is held in reset
    assign clr = {!rxc.user_ready || rxc.chan_reset,
                  !txc.user_ready || txc.chan_reset,
                  rxc.pll_reset || (shared && txc.pll_reset),
                  txc.pll_reset};
    assign dly = slow ? 8'h30 : 8'h04;
    always_ff @(posedge clk) begin
        for (int k = 0; k < 4; k++) begin
            cnt[k] <= clr[k] ? 8'h00 : cnt[k] + {7'h00, cnt[k] != 8'hFF};
        end
    end
    // Status already ANDed over all channels and PLLs
    assign tx_pll_lock   = cnt[0] > dly;
    assign rx_pll_lock   = cnt[1] > dly;
    assign rx_cdr_lock   = cnt[1] > dly + 8'h02;
    assign tx_reset_done = cnt[2] > dly;
    assign rx_reset_done = cnt[3] > dly;
    // User clocks run free, unrelated to clk
    initial tx_uclk = 1'b0;
    initial rx_uclk = 1'b0;
    always #7 tx_uclk = ~tx_uclk;
    always #9 rx_uclk = ~rx_uclk;
endmodule
`default_nettype wire

// ===== tb/srs_top_test.sv
// Self-checking bench for the reset sequencer with a channel model.
// One free-running clock; inputs change 1 ns after rising edges.
`timescale 1ns/1ps
`default_nettype none
module srs_top_test
    import srs_pkg::*;
;
    logic        clk, rst_b, pg, slow, watch;
    logic [4:0]  req;
    logic [2:0]  tie;
    logic [1:0]  act, dn, rdy;
    logic [3:0]  seen, cur, prv;
    logic [11:0] tbl [8];
    logic        tx_pll_lock, rx_pll_lock, rx_cdr_lock, tx_uclk, rx_uclk;
    logic        tx_reset_done, rx_reset_done, tx_done, rx_done;
    logic        tx_pll_reset, tx_prog_div_reset, tx_chan_reset;
    logic        rx_pll_reset, rx_prog_div_reset, rx_chan_reset;
    logic        tx_user_ready, rx_user_ready;
    srs_ctrl_s   txc, rxc;
    int          err_count, cmp_count, cycles, i;
    // Grouped views of the outputs
    assign txc = {tx_pll_reset, tx_prog_div_reset, tx_chan_reset,
                  tx_user_ready};
    assign rxc = {rx_pll_reset, rx_prog_div_reset, rx_chan_reset,
                  rx_user_ready};
    assign dn  = {rx_done, tx_done};
    assign rdy = {rx_user_ready, tx_user_ready};
    assign cur = {tx_pll_reset, tx_chan_reset, rx_pll_reset, rx_chan_reset};
    srs_top srs_top_i (
        .clk, .rst_b, .reset_all(req[0]), .reset_tx_pll_and_datapath(req[1]),
        .reset_tx_datapath(req[2]), .reset_rx_pll_and_datapath(req[3]),
        .reset_rx_datapath(req[4]), .tx_usr_clk_active(act[0]),
        .rx_usr_clk_active(act[1]), .power_good(pg), .tx_pll_lock,
        .tx_reset_done, .rx_pll_lock, .rx_cdr_lock, .rx_reset_done,
        .tx_enabled_tie(tie[2]), .rx_enabled_tie(tie[1]),
        .shared_pll_tie(tie[0]), .tx_master_user_clock(tx_uclk),
        .rx_master_user_clock(rx_uclk), .tx_pll_reset, .tx_prog_div_reset,
        .tx_chan_reset, .tx_user_ready, .rx_pll_reset, .rx_prog_div_reset,
        .rx_chan_reset, .rx_user_ready, .tx_done, .rx_done
    );
    srs_partner srs_partner_i (
        .clk, .slow, .shared(tie[0]), .txc, .rxc, .tx_pll_lock, .rx_pll_lock,
        .rx_cdr_lock, .tx_reset_done, .rx_reset_done, .tx_uclk, .rx_uclk
    );
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard and rise detector for the request table
    always @(posedge clk) begin
        cycles++;
        prv <= cur;
        seen <= watch ? (seen | (cur & ~prv)) : 4'h0;
        if (cycles == 20000) begin
            err_count++;
            $display("[ERR] %0t timeout", $time);
            test_done;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input int k);
        req[k] = 1'b1;
        tick(3);
        req[k] = 1'b0;
    endtask
    task automatic do_reset(input logic [2:0] t);
        rst_b = 1'b0;
        tie = t;
        tick(4);
        rst_b = 1'b1;
        tick(300);
    endtask
    task automatic wait_done(input int d);
        for (int n = 0; n < 400 && dn[d] !== 1'b1; n++) tick(1);
    endtask
    task automatic test_done;
        $display("Counts: %0d compares, %0d errors", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        req = 5'h00;
        act = 2'h3;
        pg = 1'b1;
        tie = 3'h6;
        slow = 1'b0;
        watch = 1'b0;
        tbl = '{12'h18F, 12'h1CD, 12'h083, 12'h10C,
                12'h38C, 12'h584, 12'h783, 12'h981};
        tick(2);
        check({4'h0, txc, dn}, 10'h038);
        check({4'h0, rxc, dn}, 10'h038);
        tick(2);
        rst_b = 1'b1;
        wait_done(0);
        wait_done(1);
        check({txc, rxc, dn}, 10'h047);
        $display("test power-up done");
        slow = 1'b1;
        for (i = 0; i < 2; i++) begin
            act[i] = 1'b0;
            pulse(i ? 4 : 2);
            tick(300);
            check({8'h00, rdy[i], dn[i]}, 10'h000);
            act[i] = 1'b1;
            wait_done(i);
            check({8'h00, rdy[i], dn[i]}, 10'h003);
            $display("test user clock gate %0d done", i);
        end
        slow = 1'b0;
        pg = 1'b0;
        pulse(1);
        tick(200);
        check({8'h00, tx_chan_reset, tx_pll_reset}, 10'h002);
        pg = 1'b1;
        wait_done(0);
        check({8'h00, tx_chan_reset, dn[0]}, 10'h001);
        $display("test power good done");
        for (i = 0; i < 8; i++) begin
            do_reset(tbl[i][8:6]);
            watch = 1'b1;
            pulse(int'(tbl[i][11:9]));
            tick(30);
            watch = 1'b0;
            check({6'h00, seen}, {6'h00, tbl[i][3:0]});
            $display("test request %0d done", i);
        end
        test_done;
    end
endmodule
`default_nettype wire
